/* hdl/bic_pkg.sv */
package bic_pkg;
	// ==================================================
	// Register indices on the special-function write port
	localparam logic [3:0] TONE_CTRL_IDX  = 4'h5;
	localparam logic [3:0] IR_CTRL_IDX    = 4'h6;
	// ==================================================
	// Field positions
	localparam int TONE_EN_BIT    = 7;
	localparam int TONE_SRC_BIT   = 3;
	localparam int IR_OSC_SEL_BIT = 7;
	localparam int IR_POL_BIT     = 2;
	localparam int IR_FREQ_BIT    = 1;
	localparam int IR_EN_BIT      = 0;
	// ==================================================
	// Reset values
	localparam logic [7:0] TONE_CTRL_RST  = 8'h0f;
	localparam logic [7:0] IR_CTRL_RST    = 8'h00;
	// Largest divider bit for the counter source (divide by 128)
	localparam logic [2:0] TONE_CNT_MAXSEL = 3'h6;
	// ==================================================
	// Carrier half periods in oscillator rising edges
	localparam int OSC_LO_KHZ        = 455;
	localparam int OSC_HI_KHZ        = 3580;
	localparam int CAR_LO_KHZ        = 38;
	localparam int CAR_HI_KHZ        = 57;
	localparam logic [6:0] HALF_LO_38 = 7'(OSC_LO_KHZ / (2 * CAR_LO_KHZ));
	localparam logic [6:0] HALF_LO_57 = 7'(OSC_LO_KHZ / (2 * CAR_HI_KHZ));
	localparam logic [6:0] HALF_HI_38 = 7'(OSC_HI_KHZ / (2 * CAR_LO_KHZ));
	localparam logic [6:0] HALF_HI_57 = 7'(OSC_HI_KHZ / (2 * CAR_HI_KHZ));
endpackage : bic_pkg

/* hdl/bic_tone_if.sv */
interface bic_tone_if;
	logic       presc_tick;
	logic       t1_run;
	logic [7:0] t1_reload;
	logic [3:0] tone_sel;
	logic       tone_level;
	logic       t1_underflow;
	modport ctrl (output presc_tick, output t1_run, output t1_reload, output tone_sel,
		input tone_level, input t1_underflow);
	modport gen (input presc_tick, input t1_run, input t1_reload, input tone_sel,
		output tone_level, output t1_underflow);
endinterface : bic_tone_if

/* hdl/bic_tone_gen.sv */
module bic_tone_gen (
	input  wire logic i_clk,
	input  wire logic i_rst,
	bic_tone_if.gen   tif
);
	// ==================================================
	// Reload down-counter and two power-of-two dividers
	logic [7:0] t1_cnt_ff,  nxt_t1_cnt;
	logic       t1_uf_ff,   nxt_t1_uf;
	logic [7:0] pdiv_ff,    nxt_pdiv;
	logic [7:0] cdiv_ff,    nxt_cdiv;
	logic       tone_ff,    nxt_tone;
	logic [2:0] csel;

	always_comb begin
		nxt_t1_cnt = t1_cnt_ff;
		nxt_t1_uf  = 1'b0;
		nxt_pdiv   = pdiv_ff;
		nxt_cdiv   = cdiv_ff;
		csel       = tif.tone_sel[2:0];
		if (tif.presc_tick) begin
			nxt_pdiv = pdiv_ff + 8'h01;
			if (tif.t1_run) begin
				if (t1_cnt_ff == 8'h00) begin
					nxt_t1_cnt = tif.t1_reload;
					nxt_t1_uf  = 1'b1;
				end else begin
					nxt_t1_cnt = t1_cnt_ff - 8'h01;
				end
			end
		end
		if (t1_uf_ff) begin
			nxt_cdiv = cdiv_ff + 8'h01;
		end
		// Counter source stops at divide by 128
		if (csel > bic_pkg::TONE_CNT_MAXSEL) begin
			csel = bic_pkg::TONE_CNT_MAXSEL;
		end
		if (tif.tone_sel[bic_pkg::TONE_SRC_BIT]) begin
			nxt_tone = cdiv_ff[csel];
		end else begin
			nxt_tone = pdiv_ff[tif.tone_sel[2:0]];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			t1_cnt_ff <= 8'h00;
			t1_uf_ff  <= 1'b0;
			pdiv_ff   <= 8'h00;
			cdiv_ff   <= 8'h00;
			tone_ff   <= 1'b0;
		end else begin
			t1_cnt_ff <= nxt_t1_cnt;
			t1_uf_ff  <= nxt_t1_uf;
			pdiv_ff   <= nxt_pdiv;
			cdiv_ff   <= nxt_cdiv;
			tone_ff   <= nxt_tone;
		end
	end

	assign tif.tone_level   = tone_ff;
	assign tif.t1_underflow = t1_uf_ff;
endmodule : bic_tone_gen

/* hdl/bic_top.sv */
module bic_top (
	input  wire logic       I_REF_CLK,
	input  wire logic       I_RESET,
	input  wire logic       I_SFR_WE,
	input  wire logic [3:0] I_SFR_IDX,
	input  wire logic [7:0] I_SFR_WDATA,
	input  wire logic       I_PRESC_TICK,
	input  wire logic       I_T1_RUN,
	input  wire logic [7:0] I_T1_RELOAD,
	input  wire logic       I_IR_OSC,
	input  wire logic       I_PB7_LATCH,
	input  wire logic       I_PB7_OE,
	input  wire logic       I_PB1_LATCH,
	input  wire logic       I_PB1_OE,
	output logic            O_PB7_OUT,
	output logic            O_PB7_OE,
	output logic            O_PB1_OUT,
	output logic            O_PB1_OE,
	output logic            O_T1_UNDERFLOW
);
	// ==================================================
	// Write-only control registers
	// There is no read path at all; software must keep a shadow copy.
	logic [7:0] tone_ctrl_ff, nxt_tone_ctrl;
	logic [7:0] ir_ctrl_ff,   nxt_ir_ctrl;

	always_comb begin
		nxt_tone_ctrl = tone_ctrl_ff;
		nxt_ir_ctrl   = ir_ctrl_ff;
		if (I_SFR_WE && (I_SFR_IDX == bic_pkg::TONE_CTRL_IDX)) begin
			nxt_tone_ctrl = I_SFR_WDATA;
		end
		if (I_SFR_WE && (I_SFR_IDX == bic_pkg::IR_CTRL_IDX)) begin
			nxt_ir_ctrl = I_SFR_WDATA;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			tone_ctrl_ff <= bic_pkg::TONE_CTRL_RST;
			ir_ctrl_ff   <= bic_pkg::IR_CTRL_RST;
		end else begin
			tone_ctrl_ff <= nxt_tone_ctrl;
			ir_ctrl_ff   <= nxt_ir_ctrl;
		end
	end

	// ==================================================
	// Tone generator
	bic_tone_if tif ();

	assign tif.presc_tick = I_PRESC_TICK;
	assign tif.t1_run     = I_T1_RUN;
	assign tif.t1_reload  = I_T1_RELOAD;
	assign tif.tone_sel   = tone_ctrl_ff[3:0];

	bic_tone_gen u_tone (
		.i_clk (I_REF_CLK),
		.i_rst (I_RESET),
		.tif   (tif.gen)
	);

	// ==================================================
	// Carrier oscillator input, from a pin, so synchronised first
	logic       osc_s1_ff, osc_s2_ff, osc_s3_ff;
	logic [6:0] half_cnt_ff, nxt_half_cnt;
	logic       car_ff,      nxt_car;
	logic [6:0] half_len;
	logic       osc_rise;

	always_comb begin
		case ({ir_ctrl_ff[bic_pkg::IR_OSC_SEL_BIT], ir_ctrl_ff[bic_pkg::IR_FREQ_BIT]})
			2'b00:   half_len = bic_pkg::HALF_LO_38;
			2'b01:   half_len = bic_pkg::HALF_LO_57;
			2'b10:   half_len = bic_pkg::HALF_HI_38;
			default: half_len = bic_pkg::HALF_HI_57;
		endcase
		osc_rise     = osc_s2_ff & ~osc_s3_ff;
		nxt_half_cnt = half_cnt_ff;
		nxt_car      = car_ff;
		// Divider held cleared while off so the first burst after enabling starts on a fresh half period
		if (!ir_ctrl_ff[bic_pkg::IR_EN_BIT]) begin
			nxt_half_cnt = 7'h00;
			nxt_car      = 1'b0;
		end else if (osc_rise) begin
			if (half_cnt_ff + 7'h01 >= half_len) begin
				nxt_half_cnt = 7'h00;
				nxt_car      = ~car_ff;
			end else begin
				nxt_half_cnt = half_cnt_ff + 7'h01;
			end
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			osc_s1_ff   <= 1'b0;
			osc_s2_ff   <= 1'b0;
			osc_s3_ff   <= 1'b0;
			half_cnt_ff <= 7'h00;
			car_ff      <= 1'b0;
		end else begin
			osc_s1_ff   <= I_IR_OSC;
			osc_s2_ff   <= osc_s1_ff;
			osc_s3_ff   <= osc_s2_ff;
			half_cnt_ff <= nxt_half_cnt;
			car_ff      <= nxt_car;
		end
	end

	// ==================================================
	// Pin multiplexing, all outputs registered
	logic nxt_pb7_out, nxt_pb7_oe, nxt_pb1_out, nxt_pb1_oe;
	logic ir_mark;

	always_comb begin
		if (tone_ctrl_ff[bic_pkg::TONE_EN_BIT]) begin
			nxt_pb7_out = tif.tone_level;
			nxt_pb7_oe  = 1'b1;
		end else begin
			nxt_pb7_out = I_PB7_LATCH;
			nxt_pb7_oe  = I_PB7_OE;
		end
		ir_mark = I_PB1_LATCH ^ ir_ctrl_ff[bic_pkg::IR_POL_BIT];
		if (ir_ctrl_ff[bic_pkg::IR_EN_BIT]) begin
			nxt_pb1_out = ir_mark & car_ff;
			nxt_pb1_oe  = 1'b1;
		end else begin
			nxt_pb1_out = I_PB1_LATCH;
			nxt_pb1_oe  = I_PB1_OE;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			O_PB7_OUT      <= 1'b0;
			O_PB7_OE       <= 1'b0;
			O_PB1_OUT      <= 1'b0;
			O_PB1_OE       <= 1'b0;
			O_T1_UNDERFLOW <= 1'b0;
		end else begin
			O_PB7_OUT      <= nxt_pb7_out;
			O_PB7_OE       <= nxt_pb7_oe;
			O_PB1_OUT      <= nxt_pb1_out;
			O_PB1_OE       <= nxt_pb1_oe;
			O_T1_UNDERFLOW <= tif.t1_underflow;
		end
	end
endmodule : bic_top

/* tb/bic_monitor.sv */
module bic_monitor (
	input wire logic       I_REF_CLK,
	input wire logic       I_RESET,
	input wire logic       I_SFR_WE,
	input wire logic [3:0] I_SFR_IDX,
	input wire logic [7:0] I_SFR_WDATA,
	input wire logic       I_PRESC_TICK,
	input wire logic       I_T1_RUN,
	input wire logic       I_PB7_LATCH,
	input wire logic       I_PB7_OE,
	input wire logic       I_PB1_LATCH,
	input wire logic       I_PB1_OE,
	input wire logic       O_PB7_OUT,
	input wire logic       O_PB7_OE,
	input wire logic       O_PB1_OUT,
	input wire logic       O_PB1_OE,
	input wire logic       O_T1_UNDERFLOW
);
	// ==================================================
	// Shadow of the write-only registers
	logic [7:0] t_ff;
	logic [7:0] r_ff;
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			t_ff <= bic_pkg::TONE_CTRL_RST;
			r_ff <= bic_pkg::IR_CTRL_RST;
		end else if (I_SFR_WE && I_SFR_IDX == bic_pkg::TONE_CTRL_IDX) begin
			t_ff <= I_SFR_WDATA;
		end else if (I_SFR_WE && I_SFR_IDX == bic_pkg::IR_CTRL_IDX) begin
			r_ff <= I_SFR_WDATA;
		end
	end
	// Cycles since the last tone register write, saturating; a new select can move the pin alone
	logic [2:0] t_calm_ff;
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET || (I_SFR_WE && I_SFR_IDX == bic_pkg::TONE_CTRL_IDX)) begin
			t_calm_ff <= 3'h0;
		end else if (t_calm_ff != 3'h7) begin
			t_calm_ff <= t_calm_ff + 3'h1;
		end
	end
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_RESET);
	sequence s_tone_on;
		I_SFR_WE && I_SFR_IDX == bic_pkg::TONE_CTRL_IDX && I_SFR_WDATA[7];
	endsequence
	a_reset_outs_low: assert property (disable iff (1'b0)
		I_RESET |=> !(O_PB7_OE || O_PB1_OE || O_PB7_OUT || O_PB1_OUT || O_T1_UNDERFLOW))
		else $error("outputs not cleared");
	a_tone_enable: assert property (s_tone_on ##1 1'b1 |=> O_PB7_OE)
		else $error("tone pin not taken");
	a_tone_oe: assert property (!$past(I_RESET) |-> O_PB7_OE == $past(t_ff[7] || I_PB7_OE))
		else $error("tone pin enable");
	a_ir_oe: assert property (!$past(I_RESET) |-> O_PB1_OE == $past(r_ff[0] || I_PB1_OE))
		else $error("ir pin enable");
	a_plain_pb7: assert property (!$past(I_RESET || t_ff[7]) |-> O_PB7_OUT == $past(I_PB7_LATCH))
		else $error("pb7 plain data");
	a_plain_pb1: assert property (!$past(I_RESET || r_ff[0]) |-> O_PB1_OUT == $past(I_PB1_LATCH))
		else $error("pb1 plain data");
	a_ir_space: assert property (!$past(I_RESET) && $past(r_ff[0] && I_PB1_LATCH == r_ff[2])
		|-> !O_PB1_OUT) else $error("carrier in space");
	a_uflow_cause: assert property (O_T1_UNDERFLOW |-> $past(I_PRESC_TICK && I_T1_RUN, 2))
		else $error("underflow without tick");
	a_tone_tick: assert property ($changed(O_PB7_OUT) && t_calm_ff >= 3'h3
		&& $past(t_ff[7] && !t_ff[3]) |-> $past(I_PRESC_TICK, 3)) else $error("tone without tick");
endmodule : bic_monitor
bind bic_top bic_monitor i_bic_monitor (.I_REF_CLK, .I_RESET, .I_SFR_WE, .I_SFR_IDX, .I_SFR_WDATA,
	.I_PRESC_TICK, .I_T1_RUN, .I_PB7_LATCH, .I_PB7_OE, .I_PB1_LATCH, .I_PB1_OE, .O_PB7_OUT,
	.O_PB7_OE, .O_PB1_OUT, .O_PB1_OE, .O_T1_UNDERFLOW);

/* tb/bic_load.sv */
module bic_load (
	input  wire logic i_clk,
	input  wire logic i_clr,
	input  wire logic i_pin,
	input  wire logic i_oe,
	output int        o_rises
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==================================================
	// Buzzer or LED: counts only driven rising edges
	logic last;
	always @(posedge i_clk) begin
		last <= i_pin;
		if (i_clr)
			o_rises <= 0;
		else if (i_oe && i_pin && !last)
			o_rises <= o_rises + 1;
	end
endmodule : bic_load

/* tb/bic_top_tb.sv */
module bic_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ==================================================
	// Stimulus
	logic       clk = 0, rst = 1, we = 0, tick = 0, run = 0, osc = 0, clr = 1;
	logic       l7 = 0, e7 = 0, l1 = 1, e1 = 0, p7, oe7, p1, oe1, uf;
	logic [3:0] idx = 4'h0;
	logic [7:0] wd = 8'h00;
	logic [7:0] rl = 8'h01;
	logic [7:0] tc [4] = '{8'h80, 8'h82, 8'h88, 8'h88};
	logic [7:0] rv [4] = '{8'h01, 8'h01, 8'h01, 8'h03};
	int         te [4] = '{16, 4, 8, 4};
	int         ue [4] = '{16, 16, 16, 8};
	logic [7:0] ic [7] = '{8'h01, 8'h03, 8'h81, 8'h83, 8'h05, 8'h05, 8'h01};
	logic       lv [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	int         hp [7] = '{1099, 1099, 140, 140, 1099, 1099, 1099};
	int         hn [7] = '{bic_pkg::HALF_LO_38, bic_pkg::HALF_LO_57, bic_pkg::HALF_HI_38,
		bic_pkg::HALF_HI_57, bic_pkg::HALF_LO_38, bic_pkg::HALF_LO_38, bic_pkg::HALF_LO_38};
	int         n_mismatch = 0, n_tests = 0, ph = 1099, nuf = 0, r7, r1;
	initial forever #20 clk = ~clk;
	always #(ph) osc = ~osc;
	always @(negedge clk) nuf <= clr ? 0 : nuf + int'(uf === 1'b1);
	bic_top i_bic_top (.I_REF_CLK(clk), .I_RESET(rst), .I_SFR_WE(we), .I_SFR_IDX(idx),
		.I_SFR_WDATA(wd), .I_PRESC_TICK(tick), .I_T1_RUN(run), .I_T1_RELOAD(rl),
		.I_IR_OSC(osc), .I_PB7_LATCH(l7), .I_PB7_OE(e7), .I_PB1_LATCH(l1), .I_PB1_OE(e1),
		.O_PB7_OUT(p7), .O_PB7_OE(oe7), .O_PB1_OUT(p1), .O_PB1_OE(oe1), .O_T1_UNDERFLOW(uf));
	bic_load i_bic_load_tone (.i_clk(clk), .i_clr(clr), .i_pin(p7), .i_oe(oe7), .o_rises(r7));
	bic_load i_bic_load_ir (.i_clk(clk), .i_clr(clr), .i_pin(p1), .i_oe(oe1), .o_rises(r1));
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		we = 1;
		idx = a;
		wd = d;
		@(negedge clk);
		we = 0;
	endtask : wr
	// Edge counts may lose one edge to divider phase
	task automatic chk(input int got, input int exp, input int tol);
		n_tests++;
		if (got < exp - tol || got > exp + tol) begin
			n_mismatch++;
			$display("[FAIL] %0t got %0d exp %0d", $time, got, exp);
		end
	endtask : chk
	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge clk);
			tick = 1;
			@(negedge clk);
			tick = 0;
			repeat (2) @(negedge clk);
		end
	endtask : ticks
	task automatic finish_test;
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	initial begin
		#2ms;
		n_mismatch++;
		finish_test();
	end
	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		wr(4'h7, 8'h80);
		repeat (3) @(negedge clk);
		chk(int'(oe7 === 1'b1), 0, 0);
		run = 1;
		for (int i = 0; i < 4; i++) begin
			rl = rv[i];
			wr(4'h5, 8'h00);
			wr(4'h5, tc[i]);
			repeat (4) @(negedge clk);
			clr = 0;
			ticks(32);
			chk(r7, te[i], 1);
			chk(nuf, ue[i], 1);
			clr = 1;
		end
		for (int i = 0; i < 7; i++) begin
			ph = hp[i];
			l1 = lv[i];
			wr(4'h6, 8'h00);
			wr(4'h6, ic[i]);
			clr = 0;
			#220us;
			chk(r1, (ic[i][2] == lv[i]) ? 0 : 220000 / (4 * hn[i] * ph), 1);
			chk(int'(oe1 === 1'b1), 1, 0);
			clr = 1;
		end
		finish_test();
	end
endmodule : bic_top_tb
